/* ebi_pkg.sv */
// constants, register map and types of the external bus interface
package ebi_pkg;
  localparam int CLK_MHZ = 100;
  localparam int INIT_US = 100;
  localparam int INIT_CYCLES = INIT_US * CLK_MHZ;
  localparam logic [3:0] CLK_DIV_HALF = 4'h1;

  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_SDRAM   = 8'h04;
  localparam logic [7:0] OFS_GPCFG   = 8'h08;
  localparam logic [7:0] OFS_ADDR    = 8'h0c;
  localparam logic [7:0] OFS_WDATA   = 8'h10;
  localparam logic [7:0] OFS_CMD     = 8'h14;
  localparam logic [7:0] OFS_RDATA   = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STS = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h28;

  localparam int GP_FRM_BIT = 0;
  localparam int GP_STB_BIT = 1;
  localparam int GP_WAIT_LSB = 8;
  localparam int CMD_WR_BIT = 0;
  localparam int CMD_NB_BIT = 1;
  localparam int CMD_BYTE_BIT = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NB_DONE = 1;
  localparam int IRQ_TIMEOUT = 2;

  localparam logic [1:0] MODE_SDRAM = 2'h0;
  localparam logic [1:0] MODE_HB16  = 2'h1;
  localparam logic [1:0] MODE_GP    = 2'h2;
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic [2:0] IRQ_RST    = 3'h0;
  localparam logic [7:0] WAIT_RST   = 8'h00;
  localparam logic [3:0] PEND_RST   = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } state_t;

  typedef struct packed {
    state_t      st;
    logic        iclk;
    logic [3:0]  div;
    logic [15:0] init_cnt;
    logic        sd_en;
    logic [1:0]  mode;
    logic        frm_en;
    logic        stb_en;
    logic [7:0]  wlimit;
    logic [7:0]  wcnt;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        cwr;
    logic        cnb;
    logic        cbyte;
    logic [3:0]  pend;
    logic [2:0]  ists;
    logic [2:0]  ien;
    logic [31:0] prdata;
    logic        rdy_s1;
    logic        rdy_s2;
  } ebi_state_t;
endpackage

/* external_bus_interface.sv */
// external bus interface: apb registers, interface clock, sdram/host-bus/general-purpose engine
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module external_bus_interface #(
  parameter int SDRAM_INIT_CYCLES = ebi_pkg::INIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq,
  output logic             interface_clock,
  output logic [15:0]      addr_line,
  output logic [15:0]      data_out,
  output logic             data_oe_n,
  input  wire logic [15:0] data_in,
  output logic [1:0]       byte_sel_n,
  output logic             chip_sel_n,
  output logic             framing_signal_line,
  output logic             read_strobe_line,
  output logic             write_strobe_line,
  input  wire logic        ready_input
);
  ebi_pkg::ebi_state_t s_ff;
  ebi_pkg::ebi_state_t nxt_s;
  logic setup;
  logic wr_acc;
  logic mapped;
  logic rise;
  logic busy;
  logic gp;
  logic start;
  logic stall;
  logic timeout;
  logic [2:0] ev;

  function automatic logic [31:0] rd_mux(input ebi_pkg::ebi_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      ebi_pkg::OFS_MODE:    r = {30'h0, s.mode};
      ebi_pkg::OFS_SDRAM:   r = {31'h0, s.sd_en};
      ebi_pkg::OFS_GPCFG:   r = {16'h0, s.wlimit, 6'h0, s.stb_en, s.frm_en};
      ebi_pkg::OFS_ADDR:    r = {16'h0, s.addr};
      ebi_pkg::OFS_WDATA:   r = {16'h0, s.wdata};
      ebi_pkg::OFS_RDATA:   r = {16'h0, s.rdata};
      ebi_pkg::OFS_STATUS:  r = {24'h0, s.pend, 1'b0, (s.init_cnt != 16'h0), (s.st != ebi_pkg::ST_IDLE),
                                 (s.st != ebi_pkg::ST_IDLE)};
      ebi_pkg::OFS_IRQ_STS: r = {29'h0, s.ists};
      ebi_pkg::OFS_IRQ_EN:  r = {29'h0, s.ien};
      default:              r = 32'h0;
    endcase
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ebi_pkg::OFS_IRQ_CLR);
  endfunction

  always_comb begin
    setup   = psel & ~penable;
    mapped  = is_mapped(paddr);
    wr_acc  = psel & penable & pwrite & mapped;
    // interface clock rises when the divider wraps with the clock low
    rise    = (s_ff.div == ebi_pkg::CLK_DIV_HALF) & ~s_ff.iclk;
    busy    = (s_ff.st != ebi_pkg::ST_IDLE);
    gp      = (s_ff.mode == ebi_pkg::MODE_GP);
    // built silicon: ready taken from the system-clock synchroniser, not an interface fall
    stall   = gp & ~s_ff.rdy_s2;
    timeout = stall & (s_ff.wlimit != 8'h0) & (s_ff.wcnt >= s_ff.wlimit);
    // a new command is refused while a transfer or nonblocking read is outstanding
    start   = wr_acc & (paddr == ebi_pkg::OFS_CMD) & ~busy & (s_ff.pend == 4'h0);
    ev      = 3'h0;

    nxt_s        = s_ff;
    nxt_s.rdy_s1 = ready_input;
    nxt_s.rdy_s2 = s_ff.rdy_s1;

    if (s_ff.div == ebi_pkg::CLK_DIV_HALF) begin
      nxt_s.div  = 4'h0;
      nxt_s.iclk = ~s_ff.iclk;
    end else begin
      nxt_s.div = s_ff.div + 4'h1;
    end

    // enabling sdram arms the hold-off; it runs in system cycles so any interface rate is covered
    if (wr_acc && paddr == ebi_pkg::OFS_SDRAM) begin
      nxt_s.sd_en = pwdata[0];
      if (pwdata[0] && !s_ff.sd_en) begin
        nxt_s.init_cnt = 16'(SDRAM_INIT_CYCLES);
      end
    end else if (s_ff.init_cnt != 16'h0) begin
      nxt_s.init_cnt = s_ff.init_cnt - 16'h1;
    end

    if (wr_acc) begin
      case (paddr)
        ebi_pkg::OFS_MODE: begin
          if (!busy) begin
            nxt_s.mode = pwdata[1:0];
          end
        end
        ebi_pkg::OFS_GPCFG: begin
          nxt_s.frm_en = pwdata[ebi_pkg::GP_FRM_BIT];
          nxt_s.stb_en = pwdata[ebi_pkg::GP_STB_BIT];
          nxt_s.wlimit = pwdata[ebi_pkg::GP_WAIT_LSB +: 8];
        end
        ebi_pkg::OFS_ADDR: begin
          if (!busy) begin
            nxt_s.addr = pwdata[15:0];
          end
        end
        ebi_pkg::OFS_WDATA: begin
          if (!busy) begin
            nxt_s.wdata = pwdata[15:0];
          end
        end
        ebi_pkg::OFS_IRQ_EN: begin
          nxt_s.ien = pwdata[2:0];
        end
        default: begin
        end
      endcase
    end

    case (s_ff.st)
      ebi_pkg::ST_IDLE: begin
        if (start) begin
          nxt_s.cwr   = pwdata[ebi_pkg::CMD_WR_BIT];
          nxt_s.cnb   = pwdata[ebi_pkg::CMD_NB_BIT] & ~pwdata[ebi_pkg::CMD_WR_BIT];
          nxt_s.cbyte = pwdata[ebi_pkg::CMD_BYTE_BIT];
          nxt_s.st    = ebi_pkg::ST_ADDR;
          nxt_s.wcnt  = 8'h0;
          if (pwdata[ebi_pkg::CMD_NB_BIT] && !pwdata[ebi_pkg::CMD_WR_BIT]) begin
            nxt_s.pend = s_ff.pend + 4'h1;
          end
        end
      end
      ebi_pkg::ST_ADDR: begin
        // sdram accesses wait for the hold-off to run out
        if (rise && !(s_ff.mode == ebi_pkg::MODE_SDRAM && s_ff.init_cnt != 16'h0)) begin
          if (stall && !timeout) begin
            nxt_s.wcnt = s_ff.wcnt + 8'h1;
          end else begin
            nxt_s.st   = ebi_pkg::ST_DATA;
            nxt_s.wcnt = 8'h0;
            ev[ebi_pkg::IRQ_TIMEOUT] = timeout;
          end
        end
      end
      ebi_pkg::ST_DATA: begin
        if (rise) begin
          if (stall && !timeout) begin
            nxt_s.wcnt = s_ff.wcnt + 8'h1;
          end else begin
            nxt_s.st = ebi_pkg::ST_IDLE;
            ev[ebi_pkg::IRQ_TIMEOUT] = timeout;
            if (!s_ff.cwr) begin
              nxt_s.rdata = data_in;
            end
            if (s_ff.cnb) begin
              nxt_s.pend = s_ff.pend - 4'h1;
              ev[ebi_pkg::IRQ_NB_DONE] = 1'b1;
            end else begin
              ev[ebi_pkg::IRQ_DONE] = 1'b1;
            end
          end
        end
      end
      default: begin
        nxt_s.st = ebi_pkg::ST_IDLE;
      end
    endcase

    // a fresh event wins over a clear in the same cycle
    if (wr_acc && paddr == ebi_pkg::OFS_IRQ_CLR) begin
      nxt_s.ists = (s_ff.ists & ~pwdata[2:0]) | ev;
    end else begin
      nxt_s.ists = s_ff.ists | ev;
    end

    if (setup) begin
      nxt_s.prdata = rd_mux(s_ff, paddr);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.st <= ebi_pkg::ST_IDLE;
      s_ff.mode <= ebi_pkg::MODE_RST;
      s_ff.wlimit <= ebi_pkg::WAIT_RST;
      s_ff.pend <= ebi_pkg::PEND_RST;
      s_ff.ists <= ebi_pkg::IRQ_RST;
      s_ff.ien <= ebi_pkg::IRQ_RST;
      s_ff.rdy_s1 <= 1'b1;
      s_ff.rdy_s2 <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    pready          = 1'b1;
    pslverr         = psel & penable & ~mapped;
    prdata          = s_ff.prdata;
    irq             = |(s_ff.ists & s_ff.ien);
    interface_clock = s_ff.iclk;
    addr_line       = s_ff.addr;
    data_out        = s_ff.wdata;
    data_oe_n       = ~(busy & s_ff.cwr);
    chip_sel_n      = ~busy;
    // reads in host-bus 16 drive both lanes even for a byte
    if (!busy) begin
      byte_sel_n = 2'b11;
    end else if (s_ff.mode == ebi_pkg::MODE_HB16 && !s_ff.cwr) begin
      byte_sel_n = 2'b00;
    end else if (s_ff.cbyte) begin
      byte_sel_n = {1'b1, s_ff.addr[0]};
    end else begin
      byte_sel_n = 2'b00;
    end
    framing_signal_line = (s_ff.st == ebi_pkg::ST_ADDR) & (~gp | s_ff.frm_en);
    read_strobe_line    = (s_ff.st == ebi_pkg::ST_DATA) & ~s_ff.cwr & (~gp | s_ff.stb_en);
    write_strobe_line   = (s_ff.st == ebi_pkg::ST_DATA) & s_ff.cwr & (~gp | s_ff.stb_en);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence nb_start_s;
    start && !pwdata[ebi_pkg::CMD_WR_BIT] && pwdata[ebi_pkg::CMD_NB_BIT];
  endsequence
  sequence enable_sdram_s;
    wr_acc && paddr == ebi_pkg::OFS_SDRAM && pwdata[0] && !s_ff.sd_en;
  endsequence

  AST_INIT_ARMED: assert property (enable_sdram_s |=> s_ff.init_cnt == 16'(SDRAM_INIT_CYCLES))
    else $error("sdram hold-off not armed");
  AST_INIT_HOLD: assert property (s_ff.mode == ebi_pkg::MODE_SDRAM && s_ff.init_cnt != 16'h0 &&
                                  s_ff.st == ebi_pkg::ST_ADDR |=> s_ff.st == ebi_pkg::ST_ADDR)
    else $error("sdram access left address phase during hold-off");
  AST_HB16_BOTH: assert property (busy && s_ff.mode == ebi_pkg::MODE_HB16 && !s_ff.cwr
                                  |-> byte_sel_n == 2'b00)
    else $error("host-bus read missing a byte select");
  AST_PEND_KEEP: assert property (s_ff.pend != 4'h0 && !(s_ff.cnb && s_ff.st == ebi_pkg::ST_DATA && rise)
                                  |=> s_ff.pend >= $past(s_ff.pend))
    else $error("pending count dropped by blocking access");
  AST_PEND_UP: assert property (nb_start_s |=> s_ff.pend == $past(s_ff.pend) + 4'h1)
    else $error("pending count not raised");
  AST_NB_IRQ: assert property (s_ff.cnb && s_ff.st == ebi_pkg::ST_DATA && rise && !stall
                               |=> s_ff.ists[ebi_pkg::IRQ_NB_DONE] && s_ff.st == ebi_pkg::ST_IDLE)
    else $error("nonblocking completion not flagged");
  AST_FRAME_GATE: assert property (gp && !s_ff.frm_en |-> !framing_signal_line)
    else $error("framing line driven while disabled");
  AST_STROBE_GATE: assert property (gp && !s_ff.stb_en |-> !read_strobe_line && !write_strobe_line)
    else $error("strobe driven while disabled");
  AST_WAIT_TICKS: assert property (!rise && busy |=> s_ff.wcnt == $past(s_ff.wcnt))
    else $error("wait counter moved off an interface edge");
  AST_READY_SYNC: assert property (gp && $fell(ready_input) ##1 1'b1 |=> ##[0:1] !s_ff.rdy_s2)
    else $error("ready change not seen within two system edges");
  AST_STALL_HOLD: assert property (busy && stall && !timeout && rise |=> s_ff.st == $past(s_ff.st))
    else $error("phase advanced during stall");
endmodule // external_bus_interface

/* periph_model.sv */
// parallel peripheral model standing on the far side of the external bus interface
`timescale 1ns/100ps
module periph_model (
  input  wire logic        interface_clock,
  input  wire logic        chip_sel_n,
  input  wire logic        data_oe_n,
  input  wire logic        stall,
  input  wire logic [15:0] rd_value,
  output logic [15:0]      data_in,
  output logic             ready_input
);
  logic [15:0] junk;
  initial begin
    ready_input = 1'b1;
    junk = 16'h0000;
  end
  // ready moves only just after an interface rise, so a data-phase stall spans the next rise
  always @(posedge interface_clock) begin
    ready_input <= !stall;
    junk <= junk + 16'h1357;
  end
  // a released data bus shows a moving pattern, never the last read value
  assign data_in = (!chip_sel_n && data_oe_n) ? rd_value : junk;
endmodule // periph_model

/* tb_top.sv */
// self-checking testbench of the external bus interface
`timescale 1ns/100ps
module tb_top;
  localparam int INIT = 20;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, iclk;
  logic        oe_n, cs_n, frm, rds, wrs, rdy, stall, bad, sf, sr, sw, bsor;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [15:0] addr_line, data_out, data_in, rdval;
  logic [1:0]  bs_n;
  int          mismatches, cmp_count, n;
  external_bus_interface #(.SDRAM_INIT_CYCLES(INIT)) external_bus_interface_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .interface_clock(iclk), .addr_line(addr_line), .data_out(data_out), .data_oe_n(oe_n),
    .data_in(data_in), .byte_sel_n(bs_n), .chip_sel_n(cs_n), .framing_signal_line(frm),
    .read_strobe_line(rds), .write_strobe_line(wrs), .ready_input(rdy));
  periph_model periph_model_i (.interface_clock(iclk), .chip_sel_n(cs_n), .data_oe_n(oe_n),
    .stall(stall), .rd_value(rdval), .data_in(data_in), .ready_input(rdy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!cs_n) begin
      sf <= sf | frm;
      sr <= sr | rds;
      sw <= sw | wrs;
      if (rds) bsor <= bsor | (bs_n != 2'b00);
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the wait for the answer ends on the first edge that sees pready high
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    bad = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle();
    n = 0;
    do begin
      apb(1'b0, ebi_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rv[0] !== 1'b0 && n < 300);
    chk("idle", 32'h0, {31'h0, rv[0]});
  endtask
  task automatic clr();
    sf <= 1'b0;
    sr <= 1'b0;
    sw <= 1'b0;
    bsor <= 1'b0;
  endtask
  task automatic t_reset();
    apb(1'b0, ebi_pkg::OFS_IRQ_STS, 32'h0);
    chk("irq status", 32'h0, rv);
    apb(1'b0, 8'h2c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, bad});
  endtask
  task automatic t_holdoff();
    apb(1'b1, ebi_pkg::OFS_SDRAM, 32'h1);
    apb(1'b1, ebi_pkg::OFS_CMD, 32'h0);
    n = 4;
    while (rds !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("sdram held off", 32'h1, {31'h0, n >= INIT && n <= INIT + 12});
    wait_idle();
    apb(1'b1, ebi_pkg::OFS_SDRAM, 32'h0);
    apb(1'b1, ebi_pkg::OFS_SDRAM, 32'h1);
    repeat (INIT + 2) @(posedge clk);
    apb(1'b0, ebi_pkg::OFS_STATUS, 32'h0);
    chk("hold-off over", 32'h0, {31'h0, rv[2]});
    apb(1'b1, ebi_pkg::OFS_CMD, 32'h0);
    wait_idle();
  endtask
  task automatic t_hb16();
    apb(1'b1, ebi_pkg::OFS_MODE, {30'h0, ebi_pkg::MODE_HB16});
    clr();
    apb(1'b1, ebi_pkg::OFS_CMD, 32'h1 << ebi_pkg::CMD_BYTE_BIT);
    wait_idle();
    chk("both lanes on read", 32'h0, {31'h0, bsor});
    chk("read strobe seen", 32'h1, {31'h0, sr});
  endtask
  task automatic t_gp();
    logic [1:0] i;
    apb(1'b1, ebi_pkg::OFS_MODE, {30'h0, ebi_pkg::MODE_GP});
    apb(1'b1, ebi_pkg::OFS_ADDR, 32'h0123);
    apb(1'b1, ebi_pkg::OFS_WDATA, 32'ha5c3);
    for (int j = 0; j < 4; j++) begin
      i = j[1:0];
      apb(1'b1, ebi_pkg::OFS_GPCFG, {30'h0, i});
      clr();
      apb(1'b1, ebi_pkg::OFS_CMD, {31'h0, ~i[0]});
      wait_idle();
      chk("frame gated", {31'h0, i[0]}, {31'h0, sf});
      chk("write strobe gated", {31'h0, i[1] & ~i[0]}, {31'h0, sw});
      chk("read strobe gated", {31'h0, i[1] & i[0]}, {31'h0, sr});
    end
    apb(1'b0, ebi_pkg::OFS_RDATA, 32'h0);
    chk("read data", {16'h0, rdval}, rv);
    chk("address lines", 32'h0123, {16'h0, addr_line});
    chk("write data lines", 32'ha5c3, {16'h0, data_out});
    chk("data released", 32'h1, {31'h0, oe_n});
  endtask
  task automatic t_nb();
    apb(1'b1, ebi_pkg::OFS_IRQ_EN, 32'h1 << ebi_pkg::IRQ_NB_DONE);
    stall <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b1, ebi_pkg::OFS_CMD, 32'h1 << ebi_pkg::CMD_NB_BIT);
    repeat (10) @(posedge clk);
    chk("address phase stalled", 32'h3, {30'h0, frm, ~rds});
    apb(1'b1, ebi_pkg::OFS_CMD, 32'h0);
    apb(1'b0, 8'h70, 32'h0);
    apb(1'b1, 8'h80, 32'h0);
    apb(1'b0, ebi_pkg::OFS_STATUS, 32'h0);
    chk("pending kept", 32'h1, {28'h0, rv[7:4]});
    chk("no early irq", 32'h0, {31'h0, irq});
    stall <= 1'b0;
    wait_idle();
    chk("pending done", 32'h0, {28'h0, rv[7:4]});
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, ebi_pkg::OFS_IRQ_EN, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, ebi_pkg::OFS_IRQ_CLR, 32'h7);
    apb(1'b0, ebi_pkg::OFS_IRQ_STS, 32'h0);
    chk("irq cleared", 32'h0, rv);
  endtask
  task automatic t_timeout();
    apb(1'b1, ebi_pkg::OFS_GPCFG, 32'h0303);
    apb(1'b1, ebi_pkg::OFS_IRQ_EN, 32'h1 << ebi_pkg::IRQ_TIMEOUT);
    stall <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b1, ebi_pkg::OFS_CMD, 32'h1);
    n = 1;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    // three interface ticks take twelve system clocks; a system-clock count ends far sooner
    chk("wait limit span", 32'h1, {31'h0, n >= 12 && n <= 26});
    stall <= 1'b0;
    wait_idle();
  endtask
  task automatic final_report();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, stall, sf, sr, sw, bsor} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rdval = 16'hc35a;
    mismatches = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_holdoff();
    t_hb16();
    t_gp();
    t_nb();
    t_timeout();
    final_report();
  end
  initial begin
    #300000;
    mismatches++;
    final_report();
  end
endmodule // tb_top
